/* File: clock_switch_pkg.sv */
package clock_switch_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] DIV_OFS = 8'h04;
   localparam logic [7:0] TRIM_OFS = 8'h08;

   // Register field positions and the trim width
   localparam int CUR_LSB = 12;
   localparam int NEW_LSB = 8;
   localparam int SELLOCK_BIT = 7;
   localparam int PLLLOCK_BIT = 5;
   localparam int FAIL_BIT = 3;
   localparam int SECONDARY_OSC_ENABLE_BIT = 1;
   localparam int REQ_BIT = 0;
   localparam int SYSDIV_LSB = 6;
   localparam int TRIM_W = 6;

   // Unlock keys, high byte then low byte
   localparam logic [7:0] KEY_HI_A = 8'h78;
   localparam logic [7:0] KEY_HI_B = 8'h9a;
   localparam logic [7:0] KEY_LO_A = 8'h46;
   localparam logic [7:0] KEY_LO_B = 8'h57;

   // Source select encodings
   localparam logic [2:0] SRC_FRC = 3'h0;
   localparam logic [2:0] SRC_FAST_RC_WITH_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI = 3'h2;
   localparam logic [2:0] SRC_PRIPLL = 3'h3;
   localparam logic [2:0] SRC_SEC = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
   localparam logic [2:0] SRC_RSVD = 3'h6;
   localparam logic [2:0] SRC_FRCDIV = 3'h7;

   // Primary submodes
   localparam logic [1:0] PSUB_EC = 2'h0;
   localparam logic [1:0] PSUB_XT = 2'h1;
   localparam logic [1:0] PSUB_HS = 2'h2;

   // Misc constants
   localparam logic SWITCH_OFF_CFG = 1'h1;
   localparam logic [3:0] NEW_CLK_WAIT = 4'ha;
   localparam logic [4:0] POST_PLL_DIV = 5'h03;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Prescaler code to divisor: 1,2,3,4,5,6,10,12
   function automatic logic [3:0] prescaleDivisor(input logic [2:0] code);
      logic [3:0] d;
      d = 4'h1;
      unique case (code)
         3'h6: d = 4'ha;
         3'h7: d = 4'hc;
         default: d = {1'h0, code} + 4'h1;
      endcase
      return d;
   endfunction

   // True for sources that run through the PLL
   function automatic logic usesPll(input logic [2:0] src);
      return (src == SRC_FAST_RC_WITH_PLL) || (src == SRC_PRIPLL);
   endfunction

   // Divisor of the 96 MHz PLL output for the system branch
   function automatic logic [4:0] sysDivisor(input logic [1:0] code);
      return POST_PLL_DIV << code;
   endfunction

endpackage

/* File: clock_switch_and_usb_pll.sv */
// Overview of operation
// - Six-bit two's-complement fast RC trim value
// - Switch-mode bit 1 disables switching, monitor
// - Disabled: new select ignored, current shows powerup
// - Disabled: request bit ignores writes, stays 0
// - High byte needs keys 78h, 9Ah first
// - Low byte needs keys 46h, 57h first
// - Equal current and new sources aborts switch
// - Valid switch clears lock and fail flags
// - Enable target; wait start-up timer or lock
// - Wait ten new-clock cycles before changeover
// - Clear request, copy new into current
// - Old source off; keep low-power RC, secondary
// - Processor keeps running during the switch
// - Primary submode fixed by configuration only
// - USB clock present while USB enabled and PLL locked
// - Prescale to 4 MHz, 96 MHz PLL, /2
// - System branch /3 then 1,2,4,8
// - Prescaler chosen by three-bit configuration field
// - Three-bit source encodings as listed
// - Monitor on plus selection lock blocks switching
`timescale 1ns/1ps
`default_nettype none
module clock_switch_and_usb_pll
   import clock_switch_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic switchModeCfg,
   input wire logic [2:0] powerupSourceCfg,
   input wire logic [1:0] primarySubmodeCfg,
   input wire logic [2:0] pllPrescaleCfg,
   input wire logic watchdogEn,
   input wire logic usbEnable,
   input wire logic oscStartupDone,
   input wire logic pllLockIn,
   input wire logic newClkToggle,
   input wire logic clockFailIn,
   output logic [2:0] sysClkSel,
   output logic fastRcEn,
   output logic primaryOscEn,
   output logic secondaryOscEn,
   output logic lowPowerRcEn,
   output logic pllEn,
   output logic usbClkEn,
   output logic [5:0] trimValue,
   output logic [3:0] pllPrescaleDiv,
   output logic [4:0] sysClkDivisor
);

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_READY = 4'h2,
      ST_COUNT = 4'h4,
      ST_DONE = 4'h8
   } sw_state_t;

   typedef enum logic [1:0] {
      KEY_NONE = 2'h0,
      KEY_FIRST = 2'h1,
      KEY_OPEN = 2'h2
   } key_state_t;

   // Straps caught while reset is held; they never change at run time
   logic switchOffCfg_ff;
   logic [2:0] powerupSrc_ff;
   logic [1:0] primarySub_ff;
   logic [2:0] prescaleCfg_ff;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         switchOffCfg_ff <= switchModeCfg;
         powerupSrc_ff <= powerupSourceCfg;
         primarySub_ff <= primarySubmodeCfg;
         prescaleCfg_ff <= pllPrescaleCfg;
      end
   end

   // Three-stage synchronisers; a level counts once stages two and three agree
   logic [5:0] syncA_ff, syncB_ff, syncC_ff, clean_ff;
   wire logic [5:0] rawPins = {clockFailIn, newClkToggle, pllLockIn, oscStartupDone, usbEnable, watchdogEn};
   wire logic [5:0] nxt_clean = (syncB_ff & syncC_ff) | (clean_ff & (syncB_ff | syncC_ff));

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         syncA_ff <= 6'h00;
         syncB_ff <= 6'h00;
         syncC_ff <= 6'h00;
         clean_ff <= 6'h00;
      end else begin
         syncA_ff <= rawPins;
         syncB_ff <= syncA_ff;
         syncC_ff <= syncB_ff;
         clean_ff <= nxt_clean;
      end
   end

   wire logic wdogOn = clean_ff[0];
   wire logic usbOn = clean_ff[1];
   wire logic ostDone = clean_ff[2];
   wire logic pllLocked = clean_ff[3];
   wire logic newClkEdge = clean_ff[4] ^ nxt_clean[4];
   wire logic failRise = nxt_clean[5] & ~clean_ff[5];

   // one strap gates switching and the fail monitor
   wire logic switchEn = (switchOffCfg_ff != SWITCH_OFF_CFG);
   wire logic monitorEn = switchEn;

   // Bus write channel holding registers
   logic awHeld_ff, wHeld_ff, awready_ff, wready_ff, bvalid_ff;
   logic [7:0] awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;
   logic [1:0] bresp_ff;
   wire logic awTake = awvalid & awready_ff;
   wire logic wTake = wvalid & wready_ff;
   wire logic doWrite = awHeld_ff & wHeld_ff & ~bvalid_ff;
   wire logic nxt_awHeld = doWrite ? 1'h0 : (awHeld_ff | awTake);
   wire logic nxt_wHeld = doWrite ? 1'h0 : (wHeld_ff | wTake);

   // Write decode on the low address byte; any upper address bit set makes the write unmapped
   wire logic wrCtrl = doWrite & (awAddr_ff == CTRL_OFS);
   wire logic wrDiv = doWrite & (awAddr_ff == DIV_OFS);
   wire logic wrTrim = doWrite & (awAddr_ff == TRIM_OFS);
   wire logic wrMapped = wrCtrl | wrDiv | wrTrim;
   wire logic wrHi = wrCtrl & wStrb_ff[1];
   wire logic wrLo = wrCtrl & wStrb_ff[0];
   wire logic [7:0] hiByte = wData_ff[15:8];
   wire logic [7:0] loByte = wData_ff[7:0];

   // Address and data are taken in either order; the answer follows both
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         awHeld_ff <= 1'h0;
         wHeld_ff <= 1'h0;
         awready_ff <= 1'h0;
         wready_ff <= 1'h0;
         bvalid_ff <= 1'h0;
         bresp_ff <= RESP_OKAY;
         awAddr_ff <= 8'h00;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
      end else begin
         awHeld_ff <= nxt_awHeld;
         wHeld_ff <= nxt_wHeld;
         awready_ff <= ~nxt_awHeld;
         wready_ff <= ~nxt_wHeld;
         if (awTake) begin
            awAddr_ff <= (awaddr[31:8] == 24'h00_0000) ? awaddr[7:0] : 8'hff;
         end
         if (wTake) begin
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
         end
         if (doWrite) begin
            bvalid_ff <= 1'h1;
            bresp_ff <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_ff <= 1'h0;
         end
      end
   end

   // Unlock key trackers, one per control byte
   key_state_t hiKey_ff, loKey_ff, nxt_hiKey, nxt_loKey;
   wire logic hiOpen = (hiKey_ff == KEY_OPEN);
   wire logic loOpen = (loKey_ff == KEY_OPEN);

   // high byte keys; any other write breaks the sequence
   assign nxt_hiKey = !doWrite ? hiKey_ff :
                      (wrHi && !hiOpen && hiByte == KEY_HI_A) ? KEY_FIRST :
                      (wrHi && hiKey_ff == KEY_FIRST && hiByte == KEY_HI_B) ? KEY_OPEN : KEY_NONE;
   assign nxt_loKey = !doWrite ? loKey_ff :
                      (wrLo && !loOpen && loByte == KEY_LO_A) ? KEY_FIRST :
                      (wrLo && loKey_ff == KEY_FIRST && loByte == KEY_LO_B) ? KEY_OPEN : KEY_NONE;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hiKey_ff <= KEY_NONE;
         loKey_ff <= KEY_NONE;
      end else begin
         hiKey_ff <= nxt_hiKey;
         loKey_ff <= nxt_loKey;
      end
   end

   // protected fields change only on the write right after the keys
   wire logic hiCommit = wrHi & hiOpen;
   wire logic loCommit = wrLo & loOpen;

   // Control and status state
   sw_state_t state_ff, nxt_state;
   logic [2:0] curSrc_ff, newSrc_ff, tgtSrc_ff;
   logic request_ff, selLock_ff, secEnable_ff, pllLockFlag_ff, failFlag_ff;
   logic [3:0] clkCount_ff;
   logic [1:0] sysDiv_ff;
   logic [5:0] trim_ff;

   wire logic selFrozen = monitorEn & selLock_ff;
   // request ignored while switching is off
   wire logic reqSet = loCommit & loByte[REQ_BIT] & switchEn & ~selFrozen;
   wire logic idle = (state_ff == ST_IDLE);
   wire logic reqSame = idle & request_ff & (newSrc_ff == curSrc_ff);
   wire logic reqStart = idle & request_ff & (newSrc_ff != curSrc_ff) & (newSrc_ff != SRC_RSVD);
   wire logic reqBad = idle & request_ff & (newSrc_ff == SRC_RSVD);

   // crystal targets wait for start-up timer, PLL targets for lock
   wire logic tgtCrystal = (tgtSrc_ff == SRC_PRI || tgtSrc_ff == SRC_PRIPLL) &&
                           (primarySub_ff == PSUB_XT || primarySub_ff == PSUB_HS);
   wire logic tgtReady = (!tgtCrystal || ostDone) && (!usesPll(tgtSrc_ff) || pllLocked);
   wire logic countDone = newClkEdge && (clkCount_ff == NEW_CLK_WAIT - 4'h1);

   // Sequencer; the processor keeps running throughout, nothing here stalls the bus
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (reqStart) begin
               nxt_state = ST_READY;
            end
         end
         ST_READY: begin
            if (tgtReady) begin
               nxt_state = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (countDone) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // count ten edges of the new clock once it is ready
   always_ff @(posedge mclk) begin
      if (!rst_b || state_ff != ST_COUNT) begin
         clkCount_ff <= 4'h0;
      end else if (newClkEdge) begin
         clkCount_ff <= clkCount_ff + 4'h1;
      end
   end

   // Target latched at start so a later select write cannot steer a switch in flight
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tgtSrc_ff <= SRC_FRC;
      end else if (reqStart) begin
         tgtSrc_ff <= newSrc_ff;
      end
   end

   // with switching off the current source is the strap, new select is inert
   // copy new into current at changeover
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         curSrc_ff <= powerupSourceCfg;
      end else if (!switchEn) begin
         curSrc_ff <= powerupSrc_ff;
      end else if (state_ff == ST_DONE) begin
         curSrc_ff <= tgtSrc_ff;
      end
   end

   // new select stored as written; reset mirrors the strap
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         newSrc_ff <= powerupSourceCfg;
      end else if (hiCommit && !selFrozen) begin
         newSrc_ff <= hiByte[NEW_LSB - 8 +: 3];
      end
   end

   // held low while switching is off
   // cleared on success; a failed wait leaves it set for software to see
   always_ff @(posedge mclk) begin
      if (!rst_b || !switchEn) begin
         request_ff <= 1'h0;
      end else if (reqSet) begin
         request_ff <= 1'h1;
      end else if (reqSame || reqBad || state_ff == ST_DONE) begin
         request_ff <= 1'h0;
      end
   end

   // Selection lock is set-only; secondary enable is plain read-write
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         selLock_ff <= 1'h0;
         secEnable_ff <= 1'h0;
      end else if (loCommit) begin
         selLock_ff <= selLock_ff | loByte[SELLOCK_BIT];
         secEnable_ff <= loByte[SECONDARY_OSC_ENABLE_BIT];
      end
   end

   // lock flag cleared at switch start and whenever no PLL source is in use
   wire logic pllInUse = usesPll(curSrc_ff) || (!idle && usesPll(tgtSrc_ff));
   always_ff @(posedge mclk) begin
      if (!rst_b || reqStart || !pllInUse) begin
         pllLockFlag_ff <= 1'h0;
      end else begin
         pllLockFlag_ff <= pllLocked;
      end
   end

   // fail flag cleared at switch start; a new failure in that cycle still sets it
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         failFlag_ff <= 1'h0;
      end else if (failRise && monitorEn) begin
         failFlag_ff <= 1'h1;
      end else if (reqStart || (loCommit && !loByte[FAIL_BIT])) begin
         failFlag_ff <= 1'h0;
      end
   end

   // trim value is plain storage, bits above read zero
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         trim_ff <= 6'h00;
         sysDiv_ff <= 2'h0;
      end else begin
         if (wrTrim && wStrb_ff[0]) begin
            trim_ff <= wData_ff[TRIM_W-1:0];
         end
         if (wrDiv && wStrb_ff[0]) begin
            sysDiv_ff <= wData_ff[SYSDIV_LSB +: 2];
         end
      end
   end

   // Oscillator demand: current source, plus target while a switch is open
   wire logic [2:0] reqA = curSrc_ff;
   wire logic [2:0] reqB = idle ? curSrc_ff : tgtSrc_ff;
   // old source drops once current moves; keepers stay on
   wire logic needFrc = (reqA == SRC_FRC || reqA == SRC_FAST_RC_WITH_PLL || reqA == SRC_FRCDIV) ||
                        (reqB == SRC_FRC || reqB == SRC_FAST_RC_WITH_PLL || reqB == SRC_FRCDIV);
   wire logic needPri = (reqA == SRC_PRI || reqA == SRC_PRIPLL) || (reqB == SRC_PRI || reqB == SRC_PRIPLL);
   wire logic needSec = (reqA == SRC_SEC) || (reqB == SRC_SEC) || secEnable_ff;
   wire logic needLprc = (reqA == SRC_LOW_POWER_RC) || (reqB == SRC_LOW_POWER_RC) || wdogOn || monitorEn;
   // PLL held on while USB is enabled; USB clock also waits for PLL lock
   wire logic needPll = usesPll(reqA) || usesPll(reqB) || usbOn;

   // All block outputs registered
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         fastRcEn <= 1'h0;
         primaryOscEn <= 1'h0;
         secondaryOscEn <= 1'h0;
         lowPowerRcEn <= 1'h0;
         pllEn <= 1'h0;
         usbClkEn <= 1'h0;
         pllPrescaleDiv <= 4'h1;
         sysClkDivisor <= POST_PLL_DIV;
      end else begin
         fastRcEn <= needFrc;
         primaryOscEn <= needPri;
         secondaryOscEn <= needSec;
         lowPowerRcEn <= needLprc;
         pllEn <= needPll;
         usbClkEn <= usbOn & pllLocked;
         // prescaler brings primary to 4 MHz for the 96 MHz PLL
         pllPrescaleDiv <= prescaleDivisor(prescaleCfg_ff);
         // system branch divides by three, then by the chosen step
         sysClkDivisor <= sysDivisor(sysDiv_ff);
      end
   end

   assign sysClkSel = curSrc_ff;
   assign trimValue = trim_ff;

   // Read data assembly
   wire logic [31:0] ctrlRead = (32'h0000_0000 | ({29'h0, curSrc_ff} << CUR_LSB) | ({29'h0, newSrc_ff} << NEW_LSB)
                                | ({31'h0, selLock_ff} << SELLOCK_BIT) | ({31'h0, pllLockFlag_ff} << PLLLOCK_BIT)
                                | ({31'h0, failFlag_ff} << FAIL_BIT) | ({31'h0, secEnable_ff} << SECONDARY_OSC_ENABLE_BIT)
                                | ({31'h0, request_ff} << REQ_BIT));
   wire logic [31:0] divRead = {30'h0, sysDiv_ff} << SYSDIV_LSB;
   wire logic [31:0] trimRead = {26'h0, trim_ff};
   wire logic rdInRange = (araddr[31:8] == 24'h00_0000);
   wire logic rdCtrl = rdInRange && (araddr[7:0] == CTRL_OFS);
   wire logic rdDiv = rdInRange && (araddr[7:0] == DIV_OFS);
   wire logic rdTrim = rdInRange && (araddr[7:0] == TRIM_OFS);
   wire logic [31:0] rdMux = rdCtrl ? ctrlRead : rdDiv ? divRead : rdTrim ? trimRead : 32'h0000_0000;
   wire logic arTake = arvalid & arready;
   wire logic nxt_rvalid = arTake | (rvalid & ~rready);

   // One read in flight; answer one cycle after the address is taken
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rvalid <= 1'h0;
         arready <= 1'h0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         rvalid <= nxt_rvalid;
         arready <= ~nxt_rvalid;
         if (arTake) begin
            rdata <= rdMux;
            rresp <= (rdCtrl | rdDiv | rdTrim) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;

endmodule
`default_nettype wire

/* File: clock_switch_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_switch_assertions
   import clock_switch_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic switchModeCfg,
   input wire logic [2:0] powerupSourceCfg,
   input wire logic [2:0] pllPrescaleCfg,
   input wire logic usbEnable,
   input wire logic [2:0] sysClkSel,
   input wire logic pllEn,
   input wire logic [5:0] trimValue,
   input wire logic [3:0] pllPrescaleDiv,
   input wire logic [4:0] sysClkDivisor
);
   // One clock domain; straps may move only while reset is low
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // Bus handshake timing
   write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
      else $error("write response missing");
   write_done_a: assert property (bvalid && bready |=> !bvalid)
      else $error("write response not retired");
   aw_refuse_a: assert property (awvalid && awready |=> !awready)
      else $error("address accepted twice");
   read_answer_a: assert property (arvalid && arready |-> ##[1:2] rvalid)
      else $error("read data missing");
   read_done_a: assert property (rvalid && rready |=> !rvalid)
      else $error("read data not retired");
   // Clock selection, PLL enable, divider and trim outputs
   source_strap_a: assert property (switchModeCfg |-> sysClkSel == powerupSourceCfg)
      else $error("current source differs from strap");
   source_gate_a: assert property ($changed(sysClkSel) |-> !switchModeCfg)
      else $error("source changed while switching off");
   usb_pll_a: assert property (usbEnable [*8] |-> pllEn)
      else $error("pll off while usb enabled");
   prescale_map_a: assert property ($past(rst_b) |-> pllPrescaleDiv == ((pllPrescaleCfg == 3'h6) ? 4'ha :
      (pllPrescaleCfg == 3'h7) ? 4'hc : {1'b0, pllPrescaleCfg} + 4'h1))
      else $error("prescaler divisor wrong");
   sysdiv_legal_a: assert property (sysClkDivisor inside {5'h03, 5'h06, 5'h0c, 5'h18})
      else $error("system divisor illegal");
   trim_write_a: assert property ($changed(trimValue) |-> bvalid)
      else $error("trim changed without a write");

   // Main scenarios reached
   cover property (bvalid && bready);
   cover property (rvalid && rready);
   cover property ($changed(sysClkSel));
endmodule

bind clock_switch_and_usb_pll clock_switch_assertions clock_switch_assertions_i (.mclk, .rst_b, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .switchModeCfg,
   .powerupSourceCfg, .pllPrescaleCfg, .usbEnable, .sysClkSel, .pllEn, .trimValue, .pllPrescaleDiv,
   .sysClkDivisor);
`default_nettype wire

/* File: clock_switch_and_usb_pll_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module clock_switch_and_usb_pll_test
   import clock_switch_pkg::*;
;
   logic mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, switchModeCfg, watchdogEn, usbEnable;
   logic oscStartupDone, pllLockIn, newClkToggle, clockFailIn, awready, wready, bvalid, arready, rvalid;
   logic fastRcEn, primaryOscEn, secondaryOscEn, lowPowerRcEn, pllEn, usbClkEn;
   logic [31:0] awaddr, wdata, araddr, rdata, rd;
   logic [3:0] wstrb, pllPrescaleDiv;
   logic [2:0] powerupSourceCfg, pllPrescaleCfg, sysClkSel;
   logic [1:0] primarySubmodeCfg, bresp, rresp, rs;
   logic [5:0] trimValue;
   logic [4:0] sysClkDivisor;
   int mismatches, compares;
   localparam logic [3:0] PDIV [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};

   clock_switch_and_usb_pll clock_switch_and_usb_pll_i (.mclk, .rst_b, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .switchModeCfg, .powerupSourceCfg, .primarySubmodeCfg, .pllPrescaleCfg, .watchdogEn, .usbEnable,
      .oscStartupDone, .pllLockIn, .newClkToggle, .clockFailIn, .sysClkSel, .fastRcEn, .primaryOscEn,
      .secondaryOscEn, .lowPowerRcEn, .pllEn, .usbClkEn, .trimValue, .pllPrescaleDiv, .sysClkDivisor);

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // One write; both channels offered together, bready held until the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 40);
      if (!bvalid) mismatches++;
      rs = bresp;
      bready <= 1'b0;
   endtask

   // One read into rd and rs
   task automatic rdr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 40);
      if (!rvalid) mismatches++;
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // Straps only settle inside reset, so every strap change costs a reset
   task automatic rst(input logic sm, input logic [2:0] pu, input logic [2:0] pd);
      rst_b <= 1'b0;
      switchModeCfg <= sm;
      powerupSourceCfg <= pu;
      pllPrescaleCfg <= pd;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask

   // For each control byte, two keys then the commit, all back to back on the bus
   task automatic req(input logic [2:0] src);
      wr(CTRL_OFS, 32'h7800, 4'h2);
      wr(CTRL_OFS, 32'h9a00, 4'h2);
      wr(CTRL_OFS, {21'h0, src, 8'h00}, 4'h2);
      wr(CTRL_OFS, 32'h46, 4'h1);
      wr(CTRL_OFS, 32'h57, 4'h1);
      wr(CTRL_OFS, 32'h9, 4'h1);
   endtask

   // New-clock cycles, slow enough for the synchroniser
   task automatic tog(input int n);
      repeat (n) begin
         repeat (6) @(posedge mclk);
         newClkToggle <= ~newClkToggle;
      end
   endtask

   // Every prescaler code, then a request with switching strapped off
   task automatic t_straps();
      for (int c = 0; c < 8; c++) begin
         rst(1'b1, SRC_LOW_POWER_RC, c[2:0]);
         `CHK(pllPrescaleDiv, PDIV[c])
         `CHK(sysClkDivisor, 5'h03)
      end
      req(SRC_PRI);
      repeat (10) @(posedge mclk);
      rdr(CTRL_OFS);
      `CHK(rd[14:12], SRC_LOW_POWER_RC)
      `CHK(rd[0], 1'b0)
      `CHK(sysClkSel, SRC_LOW_POWER_RC)
      $display("test straps done");
   endtask

   // Trim extremes and an unmapped address
   task automatic t_bus();
      wr(TRIM_OFS, 32'hffff_ffe0, 4'hf);
      `CHK(trimValue, 6'h20)
      rdr(TRIM_OFS);
      `CHK(rd, 32'h0000_0020)
      wr(TRIM_OFS, 32'h1f, 4'h1);
      `CHK(trimValue, 6'h1f)
      wr(8'h0c, 32'h1, 4'hf);
      `CHK(rs, RESP_SLVERR)
      `CHK(trimValue, 6'h1f)
      rdr(8'h0c);
      `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
      for (int c = 0; c < 4; c++) begin
         wr(DIV_OFS, {24'h0, c[1:0], 6'h0}, 4'h1);
         repeat (2) @(posedge mclk);
         `CHK(sysClkDivisor, 5'h03 << c)
      end
      $display("test bus done");
   endtask

   // Full switch from fast RC to crystal primary
   task automatic t_switch();
      rst(1'b0, SRC_FRC, 3'h1);
      clockFailIn <= 1'b1;
      repeat (8) @(posedge mclk);
      clockFailIn <= 1'b0;
      rdr(CTRL_OFS);
      `CHK(rd[3], 1'b1)
      wr(CTRL_OFS, 32'h0200, 4'h2);
      rdr(CTRL_OFS);
      `CHK(rd[10:8], SRC_FRC)
      req(SRC_PRI);
      repeat (20) @(posedge mclk);
      rdr(CTRL_OFS);
      `CHK({rd[3], rd[0]}, 2'b01)
      `CHK(primaryOscEn, 1'b1)
      oscStartupDone <= 1'b1;
      repeat (8) @(posedge mclk);
      tog(9);
      repeat (8) @(posedge mclk);
      `CHK(sysClkSel, SRC_FRC)
      tog(1);
      repeat (10) @(posedge mclk);
      `CHK(sysClkSel, SRC_PRI)
      rdr(CTRL_OFS);
      `CHK({rd[14:12], rd[0]}, {SRC_PRI, 1'b0})
      `CHK({fastRcEn, lowPowerRcEn}, 2'b01)
      $display("test switch done");
   endtask

   // Request to the source already running is dropped
   task automatic t_redund();
      req(SRC_PRI);
      repeat (10) @(posedge mclk);
      rdr(CTRL_OFS);
      `CHK(rd[0], 1'b0)
      `CHK({sysClkSel, primaryOscEn}, {SRC_PRI, 1'b1})
      req(SRC_RSVD);
      repeat (10) @(posedge mclk);
      rdr(CTRL_OFS);
      `CHK({rd[14:12], rd[0]}, {SRC_PRI, 1'b0})
      // lock on, then a refused request
      wr(CTRL_OFS, 32'h46, 4'h1);
      wr(CTRL_OFS, 32'h57, 4'h1);
      wr(CTRL_OFS, 32'h8a, 4'h1);
      repeat (2) @(posedge mclk);
      `CHK(secondaryOscEn, 1'b1)
      req(SRC_FRC);
      repeat (10) @(posedge mclk);
      rdr(CTRL_OFS);
      `CHK({rd[10:8], rd[7], rd[0]}, {SRC_RSVD, 2'b10})
      $display("test redundant done");
   endtask

   // USB clock follows enable and lock
   task automatic t_usb();
      usbEnable <= 1'b1;
      pllLockIn <= 1'b1;
      repeat (10) @(posedge mclk);
      `CHK({pllEn, usbClkEn}, 2'b11)
      usbEnable <= 1'b0;
      repeat (10) @(posedge mclk);
      `CHK(usbClkEn, 1'b0)
      $display("test usb done");
   endtask

   task automatic test_done();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence; inputs settled at time zero
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready, watchdogEn, usbEnable} = '0;
      {oscStartupDone, pllLockIn, newClkToggle, clockFailIn} = '0;
      {awaddr, wdata, araddr, wstrb} = '0;
      {switchModeCfg, powerupSourceCfg, pllPrescaleCfg, primarySubmodeCfg} = {1'b1, SRC_LOW_POWER_RC, 3'h0, PSUB_XT};
      mismatches = 0;
      compares = 0;
      @(posedge mclk);
      t_straps();
      t_bus();
      t_switch();
      t_redund();
      t_usb();
      test_done();
   end

   // Hang guard, well beyond the few hundred cycles the tests need
   initial begin
      #200us;
      mismatches++;
      test_done();
   end
endmodule
`undef CHK
`default_nettype wire
